// ### verilog/dbp_mode_reg.sv
/*
 * burst length, preamble, postamble and write-recovery mode register of the
 * memory device, with per-command burst choice and auto-precharge timer.
 * assumes mode register writes/reads, commands, set-point selects and latency
 * mode come decoded from logic on i_clock; i_link_clock is the memory clock,
 * asynchronous, and much slower than i_clock.
 */
// Contract
// - burst field: 00 fixed 16, 01 fixed 32, 10 per command, 11 reserved
// - in per-command mode the command's length bit picks 16 or 32
// - bit 2 set gives a two-cycle write preamble; zero is reserved
// - bit 3 clear gives static read preamble, set gives toggling preamble
// - normal latency: recovery codes give 6,10,16,20,24,30,34,40 cycles
// - byte latency: recovery codes give 11,19,29,38,46,56,64,75 cycles
// - after a write with auto precharge, count recovery cycles before precharge
// - bit 7 clear gives half-cycle read postamble, set gives one and half
// - mode register read returns the copy chosen by the write set-point bit
// - operation uses only the copy chosen by the operate set-point bit
// - mode register address 01 selects this register for writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "dbp_regs.svh"

module dbp_mode_reg
(
    input  wire logic                    i_clock,
    input  wire logic                    i_rstn,
    input  wire logic                    i_link_clock,
    input  wire dbp_pkg::dbp_mr_access_t i_mrw,
    input  wire logic                    i_mrr_valid,
    input  wire logic [5:0]              i_mrr_addr,
    input  wire logic                    i_setpoint_write_select,
    input  wire logic                    i_setpoint_operate_select,
    input  wire logic [1:0]              i_latency_mode,
    input  wire logic                    i_cmd_valid,
    input  wire logic                    i_cmd_burst_bit,
    input  wire logic                    i_wr_ap_done,
    output logic                         o_mrr_valid,
    output logic      [7:0]              o_mrr_data,
    output dbp_pkg::dbp_cfg_t            o_op_cfg,
    output logic      [6:0]              o_write_recovery_count,
    output logic                         o_burst_valid,
    output logic                         o_burst_is_32,
    output logic                         o_precharge_start
);

    localparam dbp_pkg::dbp_state_t RESET_STATE = '{
        link_sync1      : 1'b0,
        link_sync2      : 1'b0,
        link_prev       : 1'b0,
        mrr_valid       : 1'b0,
        mrr_data        : 8'h00,
        op_cfg          : `DBP_CFG_RESET,
        wr_recovery     : `DBP_NWR_N0,
        burst_valid     : 1'b0,
        burst_is_32     : 1'b0,
        rec_state       : dbp_pkg::DBP_REC_IDLE,
        rec_count       : 7'h00,
        precharge_start : 1'b0
    };

    dbp_pkg::dbp_state_t s_reg;
    dbp_pkg::dbp_state_t s_next;
    logic [7:0]          store_rd_data;
    logic [7:0]          store_op_data;
    logic                link_rise;
    logic                mrw_hit;

    // latency modes other than byte fall back to the normal table
    function automatic logic [6:0] recovery_cycles(input logic [1:0] lat, input logic [2:0] code);
        logic [6:0] n;
        n = `DBP_NWR_N0;
        if (lat == `DBP_LAT_BYTE)
        begin
            case (code)
                3'h0:    n = `DBP_NWR_B0;
                3'h1:    n = `DBP_NWR_B1;
                3'h2:    n = `DBP_NWR_B2;
                3'h3:    n = `DBP_NWR_B3;
                3'h4:    n = `DBP_NWR_B4;
                3'h5:    n = `DBP_NWR_B5;
                3'h6:    n = `DBP_NWR_B6;
                default: n = `DBP_NWR_B7;
            endcase
        end
        else
        begin
            case (code)
                3'h0:    n = `DBP_NWR_N0;
                3'h1:    n = `DBP_NWR_N1;
                3'h2:    n = `DBP_NWR_N2;
                3'h3:    n = `DBP_NWR_N3;
                3'h4:    n = `DBP_NWR_N4;
                3'h5:    n = `DBP_NWR_N5;
                3'h6:    n = `DBP_NWR_N6;
                default: n = `DBP_NWR_N7;
            endcase
        end
        return n;
    endfunction : recovery_cycles

    assign mrw_hit   = i_mrw.valid && (i_mrw.addr == `DBP_CFG_ADDR);
    assign link_rise = s_reg.link_sync2 && !s_reg.link_prev;

    dbp_setpoint_store u_store
    (
        .i_clock   (i_clock),
        .i_rstn    (i_rstn),
        .i_wr_en   (mrw_hit),
        .i_wr_data (i_mrw.data),
        .i_wr_sel  (i_setpoint_write_select),
        .i_op_sel  (i_setpoint_operate_select),
        .o_rd_data (store_rd_data),
        .o_op_data (store_op_data)
    );

    always_comb
    begin
        s_next = s_reg;
        s_next.link_sync1 = i_link_clock;
        s_next.link_sync2 = s_reg.link_sync1;
        s_next.link_prev  = s_reg.link_sync2;

        s_next.mrr_valid = i_mrr_valid && (i_mrr_addr == `DBP_CFG_ADDR);
        s_next.mrr_data  = s_next.mrr_valid ? store_rd_data : 8'h00;

        // preamble, postamble and burst fields drive operation from here
        s_next.op_cfg      = dbp_pkg::dbp_cfg_t'(store_op_data);
        s_next.wr_recovery = recovery_cycles(i_latency_mode, s_reg.op_cfg.write_recovery_count);

        s_next.burst_valid = i_cmd_valid;
        if (i_cmd_valid)
        begin
            case (s_reg.op_cfg.burst_length_field)
                `DBP_BL_16:      s_next.burst_is_32 = 1'b0;
                `DBP_BL_32:      s_next.burst_is_32 = 1'b1;
                `DBP_BL_PER_CMD: s_next.burst_is_32 = i_cmd_burst_bit;
                default:         s_next.burst_is_32 = 1'b0;
            endcase
        end

        // one timer; an auto-precharge write arriving while it runs is dropped
        s_next.precharge_start = 1'b0;
        case (s_reg.rec_state)
            dbp_pkg::DBP_REC_IDLE:
            begin
                if (i_wr_ap_done)
                begin
                    s_next.rec_count = s_reg.wr_recovery;
                    s_next.rec_state = dbp_pkg::DBP_REC_COUNT;
                end
            end
            dbp_pkg::DBP_REC_COUNT:
            begin
                if (link_rise)
                begin
                    if (s_reg.rec_count == 7'h01)
                    begin
                        s_next.precharge_start = 1'b1;
                        s_next.rec_count       = 7'h00;
                        s_next.rec_state       = dbp_pkg::DBP_REC_IDLE;
                    end
                    else
                    begin
                        s_next.rec_count = s_reg.rec_count - 7'h01;
                    end
                end
            end
            default:
            begin
                s_next.rec_state = dbp_pkg::DBP_REC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            s_reg <= RESET_STATE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_mrr_valid            = s_reg.mrr_valid;
    assign o_mrr_data             = s_reg.mrr_data;
    assign o_op_cfg               = s_reg.op_cfg;
    assign o_write_recovery_count = s_reg.wr_recovery;
    assign o_burst_valid          = s_reg.burst_valid;
    assign o_burst_is_32          = s_reg.burst_is_32;
    assign o_precharge_start      = s_reg.precharge_start;

    // ---- checks ----
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    sequence s_ap_accepted;
        i_wr_ap_done && s_reg.rec_state == dbp_pkg::DBP_REC_IDLE;
    endsequence

    sequence s_last_edge;
        s_reg.rec_state == dbp_pkg::DBP_REC_COUNT && s_reg.rec_count == 7'h01 && link_rise;
    endsequence

    a_mrr_answer: assert property (
        (i_mrr_valid && i_mrr_addr == `DBP_CFG_ADDR) |=> o_mrr_valid && o_mrr_data == $past(store_rd_data))
        else $error("mode register read not answered with read-back copy");

    a_mrr_other_addr: assert property (
        (i_mrr_valid && i_mrr_addr != `DBP_CFG_ADDR) |=> !o_mrr_valid)
        else $error("read of another address answered");

    a_burst_fixed16: assert property (
        (i_cmd_valid && o_op_cfg.burst_length_field == `DBP_BL_16) |=> o_burst_valid && !o_burst_is_32)
        else $error("fixed burst 16 not applied");

    a_burst_fixed32: assert property (
        (i_cmd_valid && o_op_cfg.burst_length_field == `DBP_BL_32) |=> o_burst_valid && o_burst_is_32)
        else $error("fixed burst 32 not applied");

    a_burst_per_cmd: assert property (
        (i_cmd_valid && o_op_cfg.burst_length_field == `DBP_BL_PER_CMD) |=> o_burst_is_32 == $past(i_cmd_burst_bit))
        else $error("per-command burst bit not honoured");

    a_recovery_load: assert property (
        s_ap_accepted |=> s_reg.rec_state == dbp_pkg::DBP_REC_COUNT && s_reg.rec_count == $past(o_write_recovery_count))
        else $error("recovery count not loaded");

    a_precharge_pulse: assert property (
        s_last_edge |=> o_precharge_start ##1 !o_precharge_start)
        else $error("precharge start not a single pulse after last edge");

    a_precharge_cause: assert property (
        o_precharge_start |-> $past(s_reg.rec_count) == 7'h01 && $past(s_reg.rec_state) == dbp_pkg::DBP_REC_COUNT)
        else $error("precharge start without finished count");

    a_table_normal: assert property (
        (i_latency_mode == `DBP_LAT_NORMAL && o_op_cfg.write_recovery_count == 3'h7 && $stable(o_op_cfg))
        |=> o_write_recovery_count == `DBP_NWR_N7)
        else $error("normal table wrong");

    a_table_byte: assert property (
        (i_latency_mode == `DBP_LAT_BYTE && o_op_cfg.write_recovery_count == 3'h0 && $stable(o_op_cfg))
        |=> o_write_recovery_count == `DBP_NWR_B0)
        else $error("byte table wrong");

    a_op_copy_used: assert property (
        $stable(i_setpoint_operate_select) [*3]
        |-> o_op_cfg == $past(u_store.s_reg.copy[i_setpoint_operate_select], 2))
        else $error("operating fields not from operating copy");

endmodule : dbp_mode_reg
`default_nettype wire

// ### verilog/dbp_regs.svh
/*
 * constants of the burst, preamble and write-recovery mode register:
 * address, field positions, reset value, recovery cycle tables.
 * assumes it is included by bare name from design files.
 */
`ifndef DBP_REGS_SVH
`define DBP_REGS_SVH

`define DBP_CFG_ADDR       6'h01
`define DBP_CFG_RESET      8'h04

`define DBP_BL_LSB         0
`define DBP_BL_MSB         1
`define DBP_WRPRE_BIT      2
`define DBP_RDPRE_BIT      3
`define DBP_NWR_LSB        4
`define DBP_NWR_MSB        6
`define DBP_READ_POSTAMBLE_LENGTH_BIT       7

`define DBP_BL_16          2'h0
`define DBP_BL_32          2'h1
`define DBP_BL_PER_CMD     2'h2

`define DBP_LAT_NORMAL     2'h0
`define DBP_LAT_BYTE       2'h1

// write-recovery cycles, normal latency mode
`define DBP_NWR_N0         7'h06
`define DBP_NWR_N1         7'h0A
`define DBP_NWR_N2         7'h10
`define DBP_NWR_N3         7'h14
`define DBP_NWR_N4         7'h18
`define DBP_NWR_N5         7'h1E
`define DBP_NWR_N6         7'h22
`define DBP_NWR_N7         7'h28
// write-recovery cycles, byte latency mode
`define DBP_NWR_B0         7'h0B
`define DBP_NWR_B1         7'h13
`define DBP_NWR_B2         7'h1D
`define DBP_NWR_B3         7'h26
`define DBP_NWR_B4         7'h2E
`define DBP_NWR_B5         7'h38
`define DBP_NWR_B6         7'h40
`define DBP_NWR_B7         7'h4B

`endif

// ### verilog/dbp_pkg.sv
/*
 * types of the burst, preamble and write-recovery mode register block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package dbp_pkg;

    // bit layout matches the register byte, msb first
    typedef struct packed {
        logic       postamble_long;
        logic [2:0] write_recovery_count;
        logic       rd_preamble_toggle;
        logic       wr_preamble_2tck;
        logic [1:0] burst_length_field;
    } dbp_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] addr;
        logic [7:0] data;
    } dbp_mr_access_t;

    typedef enum logic [0:0] {
        DBP_REC_IDLE,
        DBP_REC_COUNT
    } dbp_rec_state_t;

    typedef struct packed {
        logic [1:0][7:0] copy;
        logic [7:0]      rd_data;
        logic [7:0]      op_data;
    } dbp_store_state_t;

    typedef struct packed {
        logic           link_sync1;
        logic           link_sync2;
        logic           link_prev;
        logic           mrr_valid;
        logic [7:0]     mrr_data;
        dbp_cfg_t       op_cfg;
        logic [6:0]     wr_recovery;
        logic           burst_valid;
        logic           burst_is_32;
        dbp_rec_state_t rec_state;
        logic [6:0]     rec_count;
        logic           precharge_start;
    } dbp_state_t;

endpackage : dbp_pkg

// ### verilog/dbp_setpoint_store.sv
/*
 * two set-point copies of the mode register byte, with registered
 * read-back copy and registered operating copy.
 * assumes all inputs come from logic on i_clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dbp_regs.svh"

module dbp_setpoint_store
(
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr_sel,
    input  wire logic       i_op_sel,
    output logic      [7:0] o_rd_data,
    output logic      [7:0] o_op_data
);

    dbp_pkg::dbp_store_state_t s_reg;
    dbp_pkg::dbp_store_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        if (i_wr_en)
        begin
            s_next.copy[i_wr_sel] = i_wr_data;
        end
        s_next.rd_data = s_reg.copy[i_wr_sel];
        s_next.op_data = s_reg.copy[i_op_sel];
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            s_reg.copy[0] <= `DBP_CFG_RESET;
            s_reg.copy[1] <= `DBP_CFG_RESET;
            s_reg.rd_data <= `DBP_CFG_RESET;
            s_reg.op_data <= `DBP_CFG_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_rd_data = s_reg.rd_data;
    assign o_op_data = s_reg.op_data;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    // a write to the inactive copy leaves operation untouched
    a_inactive_copy_kept: assert property (
        (i_wr_en && i_wr_sel != i_op_sel) ##1 $stable(i_op_sel) |=> $stable(o_op_data))
        else $error("inactive set-point write changed operating copy");

    a_readback_copy: assert property (
        (i_wr_en && $stable(i_wr_sel)) ##1 ($stable(i_wr_sel) && !i_wr_en) |=> o_rd_data == $past(i_wr_data, 2))
        else $error("read-back copy does not show written value");

endmodule : dbp_setpoint_store
`default_nettype wire

// ### sim/dbp_ctrl_model.sv
/*
 * memory controller model: mode register accesses, commands, set-point
 * selects, latency mode and a free-running memory clock.
 * assumes i_clock comes from the bench, which calls the tasks.
 */
`timescale 1ns/1ps
`default_nettype none

module dbp_ctrl_model
(
    input  wire logic               i_clock,
    output dbp_pkg::dbp_mr_access_t o_mrw,
    output logic                    o_mrr_valid,
    output logic      [5:0]         o_mrr_addr,
    output logic                    o_wr_sel,
    output logic                    o_op_sel,
    output logic      [1:0]         o_lat,
    output logic                    o_cmd_valid,
    output logic                    o_cmd_bit,
    output logic                    o_ap_done,
    output logic                    o_link_clock
);
    initial
    begin
        o_mrw = '0;
        o_mrr_valid = 1'b0;
        o_mrr_addr = 6'h00;
        o_wr_sel = 1'b0;
        o_op_sel = 1'b0;
        o_lat = 2'h0;
        o_cmd_valid = 1'b0;
        o_cmd_bit = 1'b0;
        o_ap_done = 1'b0;
        o_link_clock = 1'b0;
        // odd offset keeps the memory clock out of phase with i_clock
        #37;
        forever #200 o_link_clock = ~o_link_clock;
    end

    // released fields carry the inverse so stale values never match
    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_mrw = '{valid: 1'b1, addr: a, data: d};
        @(posedge i_clock);
        #1;
        o_mrw = '{valid: 1'b0, addr: ~a, data: ~d};
    endtask : mrw

    // same burst code in both set points, never a reserved code
    task automatic mrw_both(input logic [7:0] d);
        o_wr_sel = 1'b0;
        mrw(6'h01, d);
        o_wr_sel = 1'b1;
        mrw(6'h01, d);
        o_wr_sel = 1'b0;
    endtask : mrw_both

    task automatic mrr(input logic [5:0] a);
        @(posedge i_clock);
        #1;
        o_mrr_valid = 1'b1;
        o_mrr_addr = a;
        @(posedge i_clock);
        #1;
        o_mrr_valid = 1'b0;
        o_mrr_addr = ~a;
    endtask : mrr

    task automatic sel(input logic ws, input logic os, input logic [1:0] lat);
        @(posedge i_clock);
        #1;
        o_wr_sel = ws;
        o_op_sel = os;
        o_lat = lat;
    endtask : sel

    task automatic cmd(input logic b);
        @(posedge i_clock);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd_bit = b;
        @(posedge i_clock);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd_bit = ~b;
    endtask : cmd

    task automatic ap();
        @(posedge i_clock);
        #1;
        o_ap_done = 1'b1;
        @(posedge i_clock);
        #1;
        o_ap_done = 1'b0;
    endtask : ap
endmodule : dbp_ctrl_model
`default_nettype wire

// ### sim/tb_top.sv
/*
 * self-checking bench of the burst/preamble/recovery mode register.
 * assumes the controller model drives every design input except clock and reset, which the bench drives.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic                    clock = 1'b0;
    logic                    rstn  = 1'b0;
    dbp_pkg::dbp_mr_access_t mrw;
    logic                    mrr_v, wr_sel, op_sel, cmd_v, cmd_b, ap_done, link, mrr_ov, bv, b32, prec;
    logic [5:0]              mrr_a;
    logic [1:0]              lat;
    logic [7:0]              mrr_d, d;
    dbp_pkg::dbp_cfg_t       op_cfg;
    logic [6:0]              wrc;
    logic [7:0]              rd_q[$];
    logic                    bl_q[$];
    int                      failures = 0;
    int                      check_count = 0;
    logic [31:0]             seed = 32'hF1ED3991;
    logic [6:0]              nwr_tab[2][8] = '{'{7'h06, 7'h0A, 7'h10, 7'h14, 7'h18, 7'h1E, 7'h22, 7'h28},
                                              '{7'h0B, 7'h13, 7'h1D, 7'h26, 7'h2E, 7'h38, 7'h40, 7'h4B}};
    int                      rises;

    always #25 clock = ~clock;

    dbp_ctrl_model i_ctl (.i_clock(clock), .o_mrw(mrw), .o_mrr_valid(mrr_v), .o_mrr_addr(mrr_a),
        .o_wr_sel(wr_sel), .o_op_sel(op_sel), .o_lat(lat), .o_cmd_valid(cmd_v), .o_cmd_bit(cmd_b),
        .o_ap_done(ap_done), .o_link_clock(link));

    dbp_mode_reg i_dut (.i_clock(clock), .i_rstn(rstn), .i_link_clock(link), .i_mrw(mrw),
        .i_mrr_valid(mrr_v), .i_mrr_addr(mrr_a), .i_setpoint_write_select(wr_sel),
        .i_setpoint_operate_select(op_sel), .i_latency_mode(lat), .i_cmd_valid(cmd_v),
        .i_cmd_burst_bit(cmd_b), .i_wr_ap_done(ap_done), .o_mrr_valid(mrr_ov), .o_mrr_data(mrr_d),
        .o_op_cfg(op_cfg), .o_write_recovery_count(wrc), .o_burst_valid(bv), .o_burst_is_32(b32),
        .o_precharge_start(prec));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic rd(input logic [7:0] e);
        rd_q.push_back(e);
        i_ctl.mrr(6'h01);
    endtask : rd

    task automatic settle;
        repeat (6) @(posedge clock);
    endtask : settle

    // results are paired with the oldest note as they appear
    always @(negedge clock)
    begin
        if (mrr_ov === 1'b1)
            chk("read data", rd_q.size() ? rd_q.pop_front() : 8'hXX, mrr_d);
        if (bv === 1'b1)
            chk("burst is 32", {7'h00, bl_q.size() ? bl_q.pop_front() : 1'bX}, {7'h00, b32});
    end

    initial
    begin
        repeat (6) @(posedge clock);
        #1;
        rstn = 1'b1;
        chk("reset cfg", 8'h04, op_cfg);
        chk("reset nwr", 8'h06, {1'b0, wrc});
        rd(8'h04);
        seed = lfsr_step(seed);
        d = {seed[7:3], 1'b1, 1'b0, seed[0]};
        i_ctl.sel(1'b1, 1'b0, 2'h0);
        i_ctl.mrw(6'h01, d);
        settle();
        chk("inactive copy", 8'h04, op_cfg);
        rd(d);
        i_ctl.sel(1'b0, 1'b0, 2'h0);
        rd(8'h04);
        i_ctl.sel(1'b0, 1'b1, 2'h0);
        settle();
        chk("active copy", d, op_cfg);
        i_ctl.mrw(6'h02, 8'hF4);
        i_ctl.mrr(6'h02);
        rd(8'h04);
        i_ctl.sel(1'b0, 1'b0, 2'h0);
        $display("test setpoints done");
        for (int l = 0; l < 2; l++)
            for (int c = 0; c < 8; c++)
            begin
                i_ctl.mrw(6'h01, {1'b0, 3'(c), 4'h4});
                i_ctl.sel(1'b0, 1'b0, 2'(l));
                settle();
                chk("recovery", {1'b0, nwr_tab[l][c]}, {1'b0, wrc});
            end
        $display("test recovery done");
        for (int b = 0; b < 3; b++)
        begin
            i_ctl.mrw_both({6'h01, 2'(b)});
            settle();
            for (int k = 0; k < 2; k++)
            begin
                bl_q.push_back(b == 1 || (b == 2 && k == 1));
                i_ctl.cmd(k[0]);
            end
        end
        $display("test burst done");
        for (int l = 0; l < 2; l++)
        begin
            i_ctl.mrw_both(8'h04);
            i_ctl.sel(1'b0, 1'b0, 2'(l));
            settle();
            // start just after a falling link edge so no rise sits in the synchroniser when the timer loads
            for (int t = 0; t < 20 && link !== 1'b1; t++)
                @(posedge clock);
            for (int t = 0; t < 20 && link !== 1'b0; t++)
                @(posedge clock);
            if (link !== 1'b0)
            begin
                failures++;
                conclude();
            end
            i_ctl.ap();
            rises = 0;
            d[0] = link;
            for (int t = 0; t <= 1000 && prec !== 1'b1; t++)
            begin
                @(posedge clock);
                #2;
                rises += (link === 1'b1 && d[0] === 1'b0);
                d[0] = link;
                if (t == 1000)
                begin
                    failures++;
                    conclude();
                end
            end
            chk("precharge delay", nwr_tab[l][0] + 8'h00, 8'(rises));
        end
        $display("test precharge done");
        i_ctl.mrw_both(8'hFD);
        settle();
        chk("before reset", 8'hFD, op_cfg);
        @(posedge clock);
        #1;
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rstn = 1'b1;
        chk("reset cfg again", 8'h04, op_cfg);
        chk("reset nwr again", 8'h06, {1'b0, wrc});
        rd(8'h04);
        $display("test reset done");
        settle();
        chk("notes left", 8'h00, 8'(rd_q.size() + bl_q.size()));
        conclude();
    end
endmodule : tb_top
`default_nettype wire
